// [hw/tracker_params.svh]
`ifndef TRACKER_PARAMS_SVH
`define TRACKER_PARAMS_SVH

// Register offsets (byte addresses, one word each)
`define OFF_LIMIT      4'h0
`define OFF_USAGE      4'h4
`define OFF_CONTROL    4'h8
`define OFF_STATUS     4'hC

// Reset values
`define LIMIT_DEFAULT  16'hFFFF
`define USAGE_DEFAULT  1'b1

// Signed wrap extremes for the default limit
`define TURN_POS_MAX   16'h7FFF
`define TURN_NEG_MIN   16'h8001

// Control register bit positions (write one to act)
`define CTL_LIMIT_WR   0
`define CTL_CLEAR_GO   1
`define CTL_KEY_BAD    2
`define CTL_ALARM_RST  3

// Status register bit positions
`define ST_MISMATCH    0
`define ST_BACKUP      1
`define ST_CHECKSUM    2
`define ST_MONITOR     3
`define ST_BUSY        4
`define ST_BAD_ENTRY   5
`define ST_MOTOR_EN    6

// Times and cycle counts at 200 MHz
`define CLK_MHZ        200
`define BAD_ENTRY_MS   1000
`define POST_DATA_MS   50
`define MS_CYCLES      (`CLK_MHZ * 1000)
`define CHAR_COUNT     8

`endif

// [hw/tracker_pkg.sv]
package tracker_pkg;
    // Transfer phases toward the host
    typedef enum logic [2:0] {
        XFER_IDLE,
        XFER_CHARS,
        XFER_PULSES,
        XFER_SETTLE,
        XFER_NORMAL
    } xfer_state_type;

    // Alarm flags carried together
    typedef struct packed {
        logic monitor;
        logic checksum;
        logic backup;
        logic mismatch;
    } alarm_type;

    // One byte for the serial stream
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } char_type;
endpackage : tracker_pkg

// [hw/tracker_char_rom.sv]
`include "tracker_params.svh"

// Builds the eight characters of the turn report, one per index, registered
module tracker_char_rom (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [2:0]  i_index,
    input  wire logic [15:0] i_turns,
    input  wire logic        i_signed,
    output logic      [7:0]  o_char
);
    logic [15:0] mag;
    logic [3:0]  digit [5];
    logic [7:0]  sel;

    // Magnitude and sign handling
    assign mag = (i_signed && i_turns[15]) ? 16'(-i_turns) : i_turns;

    // Decimal digits, least significant first
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_dig
            assign digit[g] = 4'((mag / (16'(10) ** g)) % 16'h000A);
        end
    endgenerate

    // Character selection by index
    assign sel = (i_index == 3'h0) ? 8'h50 :
                 (i_index == 3'h1) ? ((i_signed && i_turns[15]) ? 8'h2D : 8'h2B) :
                 (i_index == 3'h7) ? 8'h0D :
                 {4'h3, digit[3'(6) - i_index]};

    // Registered read data
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_char <= 8'h00;
        end else begin
            o_char <= sel;
        end
    end
endmodule : tracker_char_rom

// [hw/tracker_turn_counter.sv]
`include "tracker_params.svh"

// Multi-turn counter with signed wrap or zero-based wrap
module tracker_turn_counter (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_fwd_rev,
    input  wire logic        i_rev_rev,
    input  wire logic        i_clear,
    input  wire logic [15:0] i_limit,
    output logic      [15:0] o_turns
);
    logic        dflt;
    logic [15:0] up_val;
    logic [15:0] dn_val;
    logic [15:0] turns_next;

    assign dflt = (i_limit == `LIMIT_DEFAULT);

    assign up_val = dflt ? ((o_turns == `TURN_POS_MAX) ? `TURN_NEG_MIN : o_turns + 16'h0001)
                         : ((o_turns >= i_limit) ? 16'h0000 : o_turns + 16'h0001);
    assign dn_val = dflt ? ((o_turns == `TURN_NEG_MIN) ? `TURN_POS_MAX : o_turns - 16'h0001)
                         : ((o_turns == 16'h0000) ? i_limit : o_turns - 16'h0001);

    assign turns_next = i_clear ? 16'h0000 :
                        (i_fwd_rev && !i_rev_rev) ? up_val :
                        (i_rev_rev && !i_fwd_rev) ? dn_val : o_turns;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_turns <= 16'h0000;
        end else begin
            o_turns <= turns_next;
        end
    end
endmodule : tracker_turn_counter

// [hw/absolute_multiturn_tracker.sv]
`include "tracker_params.svh"

// How it works
// - Default limit: passing +32767 upward wraps count to -32767.
// - Default limit: passing -32767 downward wraps count to +32767.
// - Default limit keeps count in signed sixteen-bit range.
// - Other limits keep count from zero to limit, then back to zero.
// - Usage select zero means absolute, one incremental; resets to one.
// - New limit never takes effect; reset restores the stored limit to FFFF before it is latched.
// - Mismatch at power-up raises alarm; codes one and three low, two high.
// - Limit write into encoder accepted only during mismatch alarm.
// - Rising request sends turn data then initial pulses.
// - Motor stays disabled until transfer ends, servo-on ignored.
// - Confirmed clear function zeroes the turn count.
// - Backup and checksum alarms cleared only by setup, not alarm reset.
// - Encoder monitoring alarm persists until power removed.
// - Bad key entry flashes indication one second, then back.
// - Eight bytes sent, normal output about 50 ms after last.
module absolute_multiturn_tracker #(
    parameter int BAD_ENTRY_CYCLES = `BAD_ENTRY_MS * `MS_CYCLES,
    parameter int SETTLE_CYCLES    = `POST_DATA_MS * `MS_CYCLES,
    parameter int PULSE_CYCLES     = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    // Encoder side
    input  wire logic        i_fwd_rev,
    input  wire logic        i_rev_rev,
    input  wire logic [15:0] i_encoder_limit,
    input  wire logic        i_backup_fault,
    input  wire logic        i_checksum_fault,
    input  wire logic        i_monitor_fault,
    output logic      [15:0] o_encoder_limit_data,
    output logic             o_encoder_limit_load,
    // Host and amplifier side
    input  wire logic        i_sensor_on_request,
    input  wire logic        i_servo_on,
    input  wire logic        i_char_ready,
    output logic      [7:0]  o_char_data,
    output logic             o_char_valid,
    output logic             o_initial_pulse,
    output logic             o_motor_enable,
    output logic             o_alarm_code_out_1,
    output logic             o_alarm_code_out_2,
    output logic             o_alarm_code_out_3,
    output logic             o_bad_entry_prompt,
    output logic      [15:0] o_turns
);
    tracker_pkg::xfer_state_type state_reg, state_next;
    tracker_pkg::alarm_type      alarm_reg, alarm_next;
    logic [15:0] limit_reg;
    logic [15:0] active_limit_reg;
    logic        usage_reg;
    logic        started_reg;
    logic        sen_reg;
    logic        ack_reg;
    logic [31:0] rdata_next;
    logic [2:0]  index_reg;
    logic        char_sent_reg;
    logic [31:0] timer_reg, timer_next;
    logic [31:0] bad_timer_reg;
    logic [7:0]  rom_char;
    logic        wr_hit, rd_hit;
    logic        wr_limit, wr_usage, wr_ctl;
    logic        do_limit_wr, do_clear, do_bad, do_rst;
    logic        sen_rise;
    logic        last_char;

    // One wait state per access
    assign o_waitrequest = (i_read || i_write) && !ack_reg;
    assign wr_hit        = i_write && ack_reg;
    assign rd_hit        = i_read && ack_reg;

    // Address decode
    assign wr_limit = wr_hit && (i_address == `OFF_LIMIT);
    assign wr_usage = wr_hit && (i_address == `OFF_USAGE);
    assign wr_ctl   = wr_hit && (i_address == `OFF_CONTROL) && i_byteenable[0];
    assign do_limit_wr = wr_ctl && i_writedata[`CTL_LIMIT_WR] && alarm_reg.mismatch;
    assign do_clear    = wr_ctl && i_writedata[`CTL_CLEAR_GO];
    assign do_bad      = wr_ctl && i_writedata[`CTL_KEY_BAD];
    assign do_rst      = wr_ctl && i_writedata[`CTL_ALARM_RST];

    // Read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (i_address == `OFF_LIMIT) begin
            rdata_next = {16'h0000, limit_reg};
        end else if (i_address == `OFF_USAGE) begin
            rdata_next = {31'h0000_0000, usage_reg};
        end else if (i_address == `OFF_STATUS) begin
            rdata_next[`ST_MISMATCH]  = alarm_reg.mismatch;
            rdata_next[`ST_BACKUP]    = alarm_reg.backup;
            rdata_next[`ST_CHECKSUM]  = alarm_reg.checksum;
            rdata_next[`ST_MONITOR]   = alarm_reg.monitor;
            rdata_next[`ST_BUSY]      = (state_reg != tracker_pkg::XFER_NORMAL) && sen_reg;
            rdata_next[`ST_BAD_ENTRY] = o_bad_entry_prompt;
            rdata_next[`ST_MOTOR_EN]  = o_motor_enable;
        end else begin
            rdata_next = 32'h0000_0000;
        end
    end

    // Bus handshake and registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg    <= 1'b0;
            o_readdata <= 32'h0000_0000;
        end else begin
            ack_reg    <= (i_read || i_write) && !ack_reg;
            o_readdata <= rd_hit ? 32'h0000_0000 : rdata_next;
        end
    end

    // Parameter storage; usage defaults to incremental
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            limit_reg <= `LIMIT_DEFAULT;
            usage_reg <= `USAGE_DEFAULT;
        end else begin
            if (wr_limit && i_byteenable[0]) limit_reg[7:0]  <= i_writedata[7:0];
            if (wr_limit && i_byteenable[1]) limit_reg[15:8] <= i_writedata[15:8];
            if (wr_usage && i_byteenable[0]) usage_reg <= i_writedata[0];
        end
    end

    // Active limit latched once after reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            active_limit_reg <= `LIMIT_DEFAULT;
            started_reg      <= 1'b0;
        end else begin
            started_reg <= 1'b1;
            if (!started_reg) active_limit_reg <= limit_reg;
        end
    end

    // Encoder limit load strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_encoder_limit_data <= `LIMIT_DEFAULT;
            o_encoder_limit_load <= 1'b0;
        end else begin
            o_encoder_limit_load <= do_limit_wr;
            if (do_limit_wr) o_encoder_limit_data <= active_limit_reg;
        end
    end

    // Alarm updates; fault inputs win over setup clear, alarm reset wins over mismatch set
    always_comb begin
        alarm_next = alarm_reg;
        if (started_reg && !alarm_reg.mismatch && (active_limit_reg != i_encoder_limit) &&
            !o_encoder_limit_load) begin
            alarm_next.mismatch = alarm_reg.mismatch || (state_reg == tracker_pkg::XFER_IDLE &&
                                  !sen_reg && timer_reg == 32'h0000_0000);
        end
        if (do_rst && !alarm_reg.mismatch) alarm_next.mismatch = 1'b0;
        if (do_clear) begin
            alarm_next.backup   = 1'b0;
            alarm_next.checksum = 1'b0;
        end
        if (i_backup_fault)   alarm_next.backup   = 1'b1;
        if (i_checksum_fault) alarm_next.checksum = 1'b1;
        if (i_monitor_fault)  alarm_next.monitor  = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alarm_reg <= '0;
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    assign o_alarm_code_out_1 = !alarm_reg.mismatch;
    assign o_alarm_code_out_2 = 1'b1;
    assign o_alarm_code_out_3 = !alarm_reg.mismatch;

    // Turn counter
    tracker_turn_counter u_counter (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_fwd_rev (i_fwd_rev),
        .i_rev_rev (i_rev_rev),
        .i_clear   (do_clear),
        .i_limit   (active_limit_reg),
        .o_turns   (o_turns)
    );

    // Character builder
    tracker_char_rom u_rom (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_index  (index_reg),
        .i_turns  (o_turns),
        .i_signed (active_limit_reg == `LIMIT_DEFAULT),
        .o_char   (rom_char)
    );

    assign sen_rise  = i_sensor_on_request && !sen_reg;
    assign last_char = (index_reg == 3'(`CHAR_COUNT - 1));

    // Transfer sequence
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        case (state_reg)
            tracker_pkg::XFER_IDLE: begin
                timer_next = 32'h0000_0000;
                if (sen_rise && !usage_reg) state_next = tracker_pkg::XFER_CHARS;
            end
            tracker_pkg::XFER_CHARS: begin
                if (o_char_valid && i_char_ready && last_char) begin
                    state_next = tracker_pkg::XFER_PULSES;
                end
            end
            tracker_pkg::XFER_PULSES: begin
                timer_next = timer_reg + 32'h0000_0001;
                if (timer_reg == 32'(PULSE_CYCLES - 1)) begin
                    state_next = tracker_pkg::XFER_SETTLE;
                    timer_next = 32'h0000_0000;
                end
            end
            tracker_pkg::XFER_SETTLE: begin
                timer_next = timer_reg + 32'h0000_0001;
                if (timer_reg == 32'(SETTLE_CYCLES - 1)) state_next = tracker_pkg::XFER_NORMAL;
            end
            tracker_pkg::XFER_NORMAL: begin
                timer_next = 32'h0000_0000;
            end
            default: state_next = tracker_pkg::XFER_IDLE;
        endcase
        if (!i_sensor_on_request) state_next = tracker_pkg::XFER_IDLE;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= tracker_pkg::XFER_IDLE;
            timer_reg <= 32'h0000_0000;
            sen_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            sen_reg   <= i_sensor_on_request;
        end
    end

    // Character stream; ROM data one cycle behind index
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            index_reg     <= 3'h0;
            char_sent_reg <= 1'b0;
            o_char_valid  <= 1'b0;
            o_char_data   <= 8'h00;
        end else if (state_reg != tracker_pkg::XFER_CHARS) begin
            index_reg     <= 3'h0;
            char_sent_reg <= 1'b0;
            o_char_valid  <= 1'b0;
        end else if (!o_char_valid && !char_sent_reg) begin
            char_sent_reg <= 1'b1;
        end else if (!o_char_valid) begin
            o_char_valid <= 1'b1;
            o_char_data  <= rom_char;
        end else if (i_char_ready) begin
            o_char_valid  <= 1'b0;
            char_sent_reg <= 1'b0;
            index_reg     <= index_reg + 3'h1;
        end
    end

    // Initial pulse output during pulse phase
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_initial_pulse <= 1'b0;
        end else begin
            o_initial_pulse <= (state_reg == tracker_pkg::XFER_PULSES) && timer_reg[0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_motor_enable <= 1'b0;
        end else begin
            o_motor_enable <= i_servo_on && (usage_reg ||
                              state_reg == tracker_pkg::XFER_NORMAL);
        end
    end

    // Bad entry flash for one second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bad_timer_reg      <= 32'h0000_0000;
            o_bad_entry_prompt <= 1'b0;
        end else if (do_bad) begin
            bad_timer_reg      <= 32'(BAD_ENTRY_CYCLES);
            o_bad_entry_prompt <= 1'b1;
        end else if (bad_timer_reg != 32'h0000_0000) begin
            bad_timer_reg      <= bad_timer_reg - 32'h0000_0001;
            o_bad_entry_prompt <= (bad_timer_reg != 32'h0000_0001);
        end
    end
endmodule : absolute_multiturn_tracker

// [verif/tracker_monitor.sv]
module tracker_monitor #(
    parameter int BAD_ENTRY_CYCLES = 20
) (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic        i_fwd_rev,
    input wire logic        i_rev_rev,
    input wire logic        i_char_ready,
    input wire logic        o_waitrequest,
    input wire logic        o_encoder_limit_load,
    input wire logic [7:0]  o_char_data,
    input wire logic        o_char_valid,
    input wire logic        o_initial_pulse,
    input wire logic        o_motor_enable,
    input wire logic        o_alarm_code_out_1,
    input wire logic        o_alarm_code_out_2,
    input wire logic        o_alarm_code_out_3,
    input wire logic        o_bad_entry_prompt,
    input wire logic [15:0] o_turns
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [31:0] flash_reg;
    // Cycles the bad-entry prompt has stood
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) flash_reg <= 32'h0;
        else flash_reg <= o_bad_entry_prompt ? flash_reg + 32'h1 : 32'h0;
    end
    // Bus answer one cycle after request
    chk_bus_answer: assert property ($rose(i_read || i_write) |-> o_waitrequest ##1 !o_waitrequest)
        else $error("bus answer not one cycle after request");
    chk_fwd_step: assert property (
        i_fwd_rev && !i_rev_rev && !i_write && o_turns != 16'h7FFF
        |=> o_turns == $past(o_turns) + 16'h1) else $error("forward step wrong");
    chk_rev_step: assert property (
        i_rev_rev && !i_fwd_rev && !i_write && o_turns != 16'h8001
        |=> o_turns == $past(o_turns) - 16'h1) else $error("reverse step wrong");
    chk_pos_wrap: assert property (
        i_fwd_rev && !i_rev_rev && o_turns == 16'h7FFF |=> o_turns == 16'h8001)
        else $error("positive wrap wrong");
    chk_neg_wrap: assert property (
        i_rev_rev && !i_fwd_rev && o_turns == 16'h8001 |=> o_turns == 16'h7FFF)
        else $error("negative wrap wrong");
    chk_turn_cause: assert property (
        $changed(o_turns) |-> $past(i_fwd_rev ^ i_rev_rev) || $past(i_write) || $past(i_write, 2))
        else $error("count moved without cause");
    chk_code_pair: assert property (
        o_alarm_code_out_2 && (o_alarm_code_out_1 == o_alarm_code_out_3))
        else $error("alarm code pattern wrong");
    chk_load_gate: assert property (
        o_encoder_limit_load |-> !$past(o_alarm_code_out_1)) else $error("limit load without alarm");
    chk_motor_hold: assert property (
        (o_char_valid || o_initial_pulse) |-> !o_motor_enable) else $error("motor on in transfer");
    chk_char_hold: assert property (
        o_char_valid && !i_char_ready |=> o_char_valid && $stable(o_char_data))
        else $error("character dropped before ready");
    chk_flash_len: assert property (
        $fell(o_bad_entry_prompt) |-> flash_reg == 32'(BAD_ENTRY_CYCLES))
        else $error("bad entry flash length wrong");
endmodule : tracker_monitor

bind absolute_multiturn_tracker tracker_monitor #(.BAD_ENTRY_CYCLES(BAD_ENTRY_CYCLES)) u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_read(i_read), .i_write(i_write),
    .i_fwd_rev(i_fwd_rev), .i_rev_rev(i_rev_rev), .i_char_ready(i_char_ready),
    .o_waitrequest(o_waitrequest), .o_encoder_limit_load(o_encoder_limit_load),
    .o_char_data(o_char_data), .o_char_valid(o_char_valid), .o_initial_pulse(o_initial_pulse),
    .o_motor_enable(o_motor_enable), .o_alarm_code_out_1(o_alarm_code_out_1),
    .o_alarm_code_out_2(o_alarm_code_out_2), .o_alarm_code_out_3(o_alarm_code_out_3),
    .o_bad_entry_prompt(o_bad_entry_prompt), .o_turns(o_turns));

// [verif/tracker_host_model.sv]
module tracker_host_model #(
    parameter int POWER_WAIT = 8,
    parameter int REQ_WAIT   = 6
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_start,
    input  wire logic        i_slow,
    input  wire logic [7:0]  i_char_data,
    input  wire logic        i_char_valid,
    input  wire logic        i_initial_pulse,
    output logic             o_sensor_on_request,
    output logic             o_char_ready,
    output logic      [63:0] o_chars,
    output logic      [3:0]  o_count,
    output logic      [7:0]  o_pulses
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] wait_reg;
    logic        armed_reg;
    logic        pulse_reg;
    // Request, wait, then take characters and count pulses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_sensor_on_request, o_char_ready, armed_reg, pulse_reg} <= 4'h0;
            {o_chars, o_count, o_pulses, wait_reg} <= '0;
        end else begin
            pulse_reg <= i_initial_pulse;
            if (!o_sensor_on_request) begin
                if (wait_reg < 16'(POWER_WAIT)) wait_reg <= wait_reg + 16'h1;
                else if (i_start) {o_sensor_on_request, wait_reg} <= {1'b1, 16'h0};
            end else if (!armed_reg) begin
                wait_reg <= wait_reg + 16'h1;
                if (wait_reg == 16'(REQ_WAIT)) {armed_reg, o_count, o_pulses} <= {1'b1, 12'h0};
            end else begin
                o_char_ready <= i_slow ? !o_char_ready : 1'b1;
                if (i_char_valid && o_char_ready) begin
                    o_chars <= {o_chars[55:0], i_char_data};
                    o_count <= o_count + 4'h1;
                end
                if (i_initial_pulse && !pulse_reg) o_pulses <= o_pulses + 8'h1;
            end
        end
    end
endmodule : tracker_host_model

// [verif/absolute_multiturn_tracker_tb.sv]
module absolute_multiturn_tracker_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk, i_rst_n, i_read, i_write, i_fwd_rev, i_rev_rev, i_servo_on;
    logic        i_backup_fault, i_checksum_fault, i_monitor_fault, h_start, h_slow;
    logic        h_req, h_ready, o_waitrequest, o_char_valid, o_pulse, o_motor_enable;
    logic        o_load, o_code_1, o_code_2, o_code_3, o_prompt, load_seen;
    logic [3:0]  i_address, i_byteenable, h_count;
    logic [31:0] i_writedata, o_readdata;
    logic [15:0] i_encoder_limit, o_turns, o_lim_data;
    logic [7:0]  o_char_data, h_pulses;
    logic [63:0] h_chars;
    int          num_errors, n_tests;

    absolute_multiturn_tracker #(.BAD_ENTRY_CYCLES(20), .SETTLE_CYCLES(10), .PULSE_CYCLES(4)) u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_fwd_rev(i_fwd_rev),
        .i_rev_rev(i_rev_rev), .i_encoder_limit(i_encoder_limit),
        .i_backup_fault(i_backup_fault), .i_checksum_fault(i_checksum_fault),
        .i_monitor_fault(i_monitor_fault), .o_encoder_limit_data(o_lim_data),
        .o_encoder_limit_load(o_load),
        .i_sensor_on_request(h_req), .i_servo_on(i_servo_on), .i_char_ready(h_ready),
        .o_char_data(o_char_data), .o_char_valid(o_char_valid), .o_initial_pulse(o_pulse),
        .o_motor_enable(o_motor_enable), .o_alarm_code_out_1(o_code_1),
        .o_alarm_code_out_2(o_code_2), .o_alarm_code_out_3(o_code_3),
        .o_bad_entry_prompt(o_prompt), .o_turns(o_turns));

    tracker_host_model u_host (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(h_start), .i_slow(h_slow),
        .i_char_data(o_char_data), .i_char_valid(o_char_valid), .i_initial_pulse(o_pulse),
        .o_sensor_on_request(h_req), .o_char_ready(h_ready), .o_chars(h_chars),
        .o_count(h_count), .o_pulses(h_pulses));

    // Clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Remember any limit load pulse
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) load_seen <= 1'b0;
        else if (o_load === 1'b1) load_seen <= 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("errors %0d, comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge i_clk);
        i_address   <= a;
        i_writedata <= d;
        i_write     <= wr;
        i_read      <= !wr;
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x & m, e);
    endtask : rd_chk

    task automatic turn(input logic f, input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_fwd_rev <= f;
            i_rev_rev <= !f;
            @(posedge i_clk);
            i_fwd_rev <= 1'b0;
            i_rev_rev <= 1'b0;
        end
        repeat (2) @(negedge i_clk);
    endtask : turn

    task automatic power_up;
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask : power_up

    // Main sequence
    initial begin
        {i_rst_n, i_read, i_write, i_fwd_rev, i_rev_rev, i_servo_on} = 6'h0;
        {i_backup_fault, i_checksum_fault, i_monitor_fault, h_start, h_slow} = 5'h0;
        {i_address, i_writedata} = 36'h0;
        {i_byteenable, i_encoder_limit} = 20'hF_FFFF;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd_chk(4'h0, 32'hFFFF, 32'hFFFF);
        rd_chk(4'h4, 32'h1, 32'h1);
        rd_chk(4'h1, 32'hFFFFFFFF, 32'h0);
        check(o_code_1, 32'h1);
        wr(4'h0, 32'h5);
        rd_chk(4'h0, 32'hFFFF, 32'h5);
        turn(1'b1, 7);
        check(o_turns, 32'h7);
        wr(4'h8, 32'h2);
        repeat (2) @(negedge i_clk);
        check(o_turns, 32'h0);
        turn(1'b1, 32768);
        check(o_turns, 32'h8001);
        turn(1'b0, 1);
        check(o_turns, 32'h7FFF);
        wr(4'h8, 32'h2);
        turn(1'b0, 1);
        check(o_turns, 32'hFFFF);
        // Encoder faults, then alarm reset, then setup
        @(posedge i_clk);
        {i_backup_fault, i_checksum_fault, i_monitor_fault} <= 3'h7;
        @(posedge i_clk);
        {i_backup_fault, i_checksum_fault, i_monitor_fault} <= 3'h0;
        rd_chk(4'hC, 32'hF, 32'hE);
        wr(4'h8, 32'h8);
        rd_chk(4'hC, 32'hF, 32'hE);
        wr(4'h8, 32'h2);
        rd_chk(4'hC, 32'hF, 32'h8);
        wr(4'h8, 32'h4);
        @(negedge i_clk);
        check(o_prompt, 32'h1);
        repeat (24) @(negedge i_clk);
        check(o_prompt, 32'h0);
        wr(4'h8, 32'h1);
        check(load_seen, 32'h0);
        i_encoder_limit <= 16'h0010;
        repeat (4) @(negedge i_clk);
        check({o_code_1, o_code_2, o_code_3}, 32'h2);
        rd_chk(4'hC, 32'h1, 32'h1);
        wr(4'h8, 32'h1);
        repeat (2) @(negedge i_clk);
        check(load_seen, 32'h1);
        check(o_lim_data, 32'hFFFF);
        wr(4'h8, 32'h8);
        check(o_code_1, 32'h0);
        i_encoder_limit <= 16'hFFFF;
        power_up();
        rd_chk(4'h0, 32'hFFFF, 32'hFFFF);
        rd_chk(4'hC, 32'hF, 32'h0);
        i_servo_on <= 1'b1;
        repeat (3) @(negedge i_clk);
        check(o_motor_enable, 32'h1);
        wr(4'h4, 32'h0);
        turn(1'b1, 3);
        check(o_motor_enable, 32'h0);
        @(posedge i_clk);
        {h_start, h_slow} <= 2'h3;
        for (int k = 0; k < 400 && h_count !== 4'h8; k++) @(negedge i_clk);
        check(o_motor_enable, 32'h0);
        check(h_chars[63:32], 32'h502B3030);
        check(h_chars[31:0], 32'h3030330D);
        repeat (40) @(negedge i_clk);
        check(h_pulses != 8'h0, 32'h1);
        check(h_count, 32'h8);
        check(o_motor_enable, 32'h1);
        end_of_test();
    end

    // Watchdog
    initial begin
        repeat (100000) @(posedge i_clk);
        num_errors++;
        end_of_test();
    end
endmodule : absolute_multiturn_tracker_tb
